/* core/spi_front_cfg.svh */
// Named constants of the serial memory front end: opcodes, bit counts,
// status field positions, array size and write cycle timing.
// Assumes inclusion by bare name from the design modules.
`ifndef SPI_FRONT_CFG_SVH
`define SPI_FRONT_CFG_SVH

// Instruction bytes
`define OP_WRSR       8'h01
`define OP_WRITE      8'h02
`define OP_READ       8'h03
`define OP_WRDI       8'h04
`define OP_RDSR       8'h05
`define OP_WREN       8'h06

// Bit counter landmarks within a frame
`define CNT_FIRST     6'h00
`define CNT_OP_END    6'h07
`define CNT_SR_START  6'h08
`define CNT_SR_END    6'h0f
`define CNT_AD_FIRST  6'h08
`define CNT_ADDR_END  6'h17
`define CNT_DATA_START 6'h18
`define CNT_DATA_END  6'h1f

// Status byte field positions
`define ST_PE         7
`define ST_BP1        3
`define ST_BP0        2
`define ST_WEL        1
`define ST_WIP        0
`define ST_RESET      8'h00

// Array size and widths
`define MEM_AW        8
`define MEM_DEPTH     256
`define TMR_W         17

// Write cycle time, longest, and the core clock rate
`define TWC_MS        6
`define CLK_HZ        20000000
`define MS_PER_S      1000

`endif

/* core/spi_front_pkg.sv */
// Types shared by the serial memory front end.
// Assumes spi_front_cfg.svh is on the include path.
package spi_front_pkg;

  // Kind of frame that a deselect edge would close
  typedef enum logic [4:0] {
    kind_none  = 5'h01,
    kind_wren  = 5'h02,
    kind_wrdi  = 5'h04,
    kind_write = 5'h08,
    kind_wrsr  = 5'h10
  } commit_e;

  // Internal write cycle state
  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_busy = 2'h2
  } wstate_e;

  typedef logic [7:0] byte_t;

endpackage : spi_front_pkg

/* core/spi_front_mem.sv */
// Byte array with a write port on the core clock and a read port on the serial clock.
// Assumes the two ports never touch the array at once; the front end writes the array only after deselect, while sck idles.
`timescale 1ns/10ps
`include "spi_front_cfg.svh"

module spi_front_mem (
  // Write port, core clock
  input  wire logic                  wr_clk,
  input  wire logic                  wr_en,
  input  wire logic [`MEM_AW-1:0]    wr_addr,
  input  wire logic [7:0]            wr_data,
  // Read port, serial clock
  input  wire logic                  rd_clk,
  input  wire logic                  rd_en,
  input  wire logic [`MEM_AW-1:0]    rd_addr,
  output logic      [7:0]            rd_data
);

  // Storage, no reset: contents are nonvolatile in spirit
  logic [7:0] mem [`MEM_DEPTH];

  // Write side
  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the output clean for the falling edge launch
  always_ff @(posedge rd_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : spi_front_mem

/* core/spi_eeprom_select_protect_front.sv */
// Serial memory front end: select, standby, tri-state, deselect-started writes and write protect.
// Assumes sck idles while cs_n is high and that the host keeps hold tied inactive outside this block.
// What this block does
// - Low select selects; high select means standby once no write cycle runs
// - Started write cycle always runs to completion
// - Standby entered only after running write ends
// - Data output high impedance while deselected
// - Deselect after valid write sequence starts write
// - Write cycle lasts at most six milliseconds
// - Output bits launched after falling clock edge
// - Input bits captured on rising clock edge
// - Protect pin low plus enable refuses status writes
// - Protect pin high allows every operation
// - Pin low during status write blocks it
// - Pin falling mid-write leaves write unaffected
// - Enable bit clear makes protect pin ignored
// - All transfers most significant bit first
// - Array reads refused while write in progress
`timescale 1ns/10ps
`include "spi_front_cfg.svh"

module spi_eeprom_select_protect_front #(
  parameter int unsigned WRITE_CYCLES = `TWC_MS * `CLK_HZ / `MS_PER_S
) (
  // Core clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Serial link pins
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  output logic      so,
  output logic      so_oe,
  // Device state
  output logic      standby,
  output logic      write_busy
);

  // ---------------- Link domain, rising edge ----------------
  logic [7:0]          sh_r, sh_nxt;        // Input shift register
  logic [5:0]          cnt_r, cnt_nxt;      // Bit position in this frame, reloaded after each data byte and each RDSR status byte
  logic [7:0]          op_r, op_nxt;        // Latched instruction
  logic [15:0]         addr_r, addr_nxt;    // Latched address
  logic [`MEM_AW-1:0]  ptr_r, ptr_nxt;      // Sequential read pointer
  logic                rd_ok_r, rd_ok_nxt;  // Read allowed this frame
  logic                rd_en;               // Array read strobe
  logic [`MEM_AW-1:0]  rd_addr;             // Array read address
  logic [7:0]          mem_q;               // Registered array data
  // Frame summary, survives deselect so the core can pick it up
  spi_front_pkg::commit_e kind_r, kind_nxt;
  logic                tag_r, tag_nxt;      // Flips on each frame start
  logic [15:0]         waddr_r, waddr_nxt;
  logic [7:0]          wdata_r, wdata_nxt;
  // Core state seen from the link
  logic [7:0]          st_meta_r, st_sync_r;
  logic                link_rst;            // Frame reset
  // Core-domain state and array write port, declared ahead of their first readers
  logic [7:0]          status_r, status_nxt; // Protect, block and latch bits
  logic                mem_we;              // Array write strobe
  logic [`MEM_AW-1:0]  mem_waddr;           // Array write address
  logic [7:0]          mem_wdata;           // Array write data

  // Deselect ends a frame at once, no sck edge needed
  assign link_rst = cs_n | reset;

  // Next frame state per captured bit
  always_comb begin
    sh_nxt    = {sh_r[6:0], si};
    cnt_nxt   = cnt_r + 6'h01;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    ptr_nxt   = ptr_r;
    rd_ok_nxt = rd_ok_r;
    rd_en     = 1'b0;
    rd_addr   = ptr_r;
    kind_nxt  = spi_front_pkg::kind_none;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    tag_nxt   = (cnt_r == `CNT_FIRST) ? ~tag_r : tag_r;
    // Instruction byte complete
    if (cnt_r == `CNT_OP_END) begin
      op_nxt = sh_nxt;
      if (sh_nxt == `OP_WREN) begin
        kind_nxt = spi_front_pkg::kind_wren;
      end else if (sh_nxt == `OP_WRDI) begin
        kind_nxt = spi_front_pkg::kind_wrdi;
      end
    end
    // Address bits for read and write
    if ((op_r == `OP_READ || op_r == `OP_WRITE) && cnt_r >= `CNT_AD_FIRST && cnt_r <= `CNT_ADDR_END) begin
      addr_nxt = {addr_r[14:0], si};
    end
    // Address complete: fetch first byte and note whether a write runs
    if (cnt_r == `CNT_ADDR_END && op_r == `OP_READ) begin
      rd_en     = 1'b1;
      rd_addr   = addr_nxt[`MEM_AW-1:0];
      ptr_nxt   = addr_nxt[`MEM_AW-1:0] + `MEM_AW'(1);
      rd_ok_nxt = ~st_sync_r[`ST_WIP];
    end
    // Data byte complete
    if (cnt_r == `CNT_DATA_END) begin
      cnt_nxt = `CNT_DATA_START;
      if (op_r == `OP_READ) begin
        rd_en   = 1'b1;
        ptr_nxt = ptr_r + `MEM_AW'(1);
      end
      if (op_r == `OP_WRITE) begin
        kind_nxt  = spi_front_pkg::kind_write;
        waddr_nxt = addr_r;
        wdata_nxt = sh_nxt;
      end
    end
    // Status byte boundaries
    if (cnt_r == `CNT_SR_END && op_r == `OP_RDSR) begin
      cnt_nxt = `CNT_SR_START;
    end
    if (cnt_r == `CNT_SR_END && op_r == `OP_WRSR) begin
      kind_nxt  = spi_front_pkg::kind_wrsr;
      wdata_nxt = sh_nxt;
    end
  end

  // Frame registers, capture on rising sck
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      sh_r    <= 8'h00;
      cnt_r   <= `CNT_FIRST;
      op_r    <= 8'h00;
      addr_r  <= 16'h0000;
      ptr_r   <= {`MEM_AW{1'b0}};
      rd_ok_r <= 1'b0;
    end else begin
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      ptr_r   <= ptr_nxt;
      rd_ok_r <= rd_ok_nxt;
    end
  end

  // Summary and status synchroniser, kept across deselect
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      kind_r    <= spi_front_pkg::kind_none;
      tag_r     <= 1'b0;
      waddr_r   <= 16'h0000;
      wdata_r   <= 8'h00;
      st_meta_r <= `ST_RESET;
      st_sync_r <= `ST_RESET;
    end else begin
      kind_r    <= kind_nxt;
      tag_r     <= tag_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      st_meta_r <= status_r;
      st_sync_r <= st_meta_r;
    end
  end

  // ---------------- Link domain, falling edge ----------------
  logic [7:0] out_r, out_nxt;   // Output shift register
  logic       so_nxt;
  logic       so_oe_nxt;

  // Load a byte at each read data or status byte start, else shift toward the pin
  always_comb begin
    out_nxt   = {out_r[6:0], 1'b0};
    so_oe_nxt = so_oe;
    if (op_r == `OP_READ && cnt_r == `CNT_DATA_START) begin
      out_nxt   = mem_q;
      so_oe_nxt = rd_ok_r;
    end else if (op_r == `OP_RDSR && cnt_r == `CNT_SR_START) begin
      out_nxt   = st_sync_r;
      so_oe_nxt = 1'b1;
    end
    so_nxt = out_nxt[7];
  end

  // Launch after the falling edge; deselect floats the pin at once
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      out_r <= 8'h00;
      so    <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      out_r <= out_nxt;
      so    <= so_nxt;
      so_oe <= so_oe_nxt;
    end
  end

  // Byte array
  spi_front_mem u_mem (
    .wr_clk  (clk),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_clk  (sck),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (mem_q)
  );

  // ---------------- Core domain ----------------
  logic                    cs_meta_r, cs_sync_r, cs_prev_r;  // Select synchroniser
  logic                    wp_meta_r, wp_sync_r;             // Protect pin synchroniser
  logic                    armed_r, armed_nxt;               // Select seen low since reset
  logic                    wp_low_r, wp_low_nxt;             // Pin low during this frame
  logic                    tag_seen_r, tag_seen_nxt;         // Last frame consumed
  spi_front_pkg::wstate_e  state_r, state_nxt;
  logic [`TMR_W-1:0]       tmr_r, tmr_nxt;                   // Write cycle countdown
  logic                    standby_nxt;
  logic                    cs_rise;
  logic                    cs_fall;
  logic                    commit;
  logic                    protect;

  // Pin synchronisers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      wp_meta_r <= 1'b1;
      wp_sync_r <= 1'b1;
    end else begin
      cs_meta_r <= cs_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      wp_meta_r <= wp_n;
      wp_sync_r <= wp_meta_r;
    end
  end

  assign cs_rise = cs_sync_r & ~cs_prev_r;
  assign cs_fall = ~cs_sync_r & cs_prev_r;
  // Summary is still while select is high and sck idles, so the edge acts as handshake
  assign commit  = cs_rise & armed_r & (tag_r != tag_seen_r);
  // Pin counts only when the enable bit is set
  assign protect = status_r[`ST_PE] & (wp_low_r | ~wp_sync_r);

  // Write cycle, status and latch next values
  always_comb begin
    state_nxt    = state_r;
    tmr_nxt      = tmr_r;
    status_nxt   = status_r;
    armed_nxt    = armed_r | ~cs_sync_r;
    tag_seen_nxt = cs_rise ? tag_r : tag_seen_r;
    wp_low_nxt   = cs_fall ? ~wp_sync_r : (wp_low_r | (~cs_sync_r & ~wp_sync_r));
    mem_we       = 1'b0;
    mem_waddr    = waddr_r[`MEM_AW-1:0];
    mem_wdata    = wdata_r;
    unique case (state_r)
      spi_front_pkg::st_idle: begin
        if (commit) begin
          unique case (kind_r)
            spi_front_pkg::kind_wren: begin
              status_nxt[`ST_WEL] = 1'b1;
            end
            spi_front_pkg::kind_wrdi: begin
              status_nxt[`ST_WEL] = 1'b0;
            end
            spi_front_pkg::kind_write: begin
              if (status_r[`ST_WEL]) begin
                mem_we    = 1'b1;
                state_nxt = spi_front_pkg::st_busy;
                tmr_nxt   = `TMR_W'(WRITE_CYCLES - 1);
              end
            end
            spi_front_pkg::kind_wrsr: begin
              if (status_r[`ST_WEL] && !protect) begin
                status_nxt[`ST_PE]  = wdata_r[`ST_PE];
                status_nxt[`ST_BP1] = wdata_r[`ST_BP1];
                status_nxt[`ST_BP0] = wdata_r[`ST_BP0];
                state_nxt           = spi_front_pkg::st_busy;
                tmr_nxt             = `TMR_W'(WRITE_CYCLES - 1);
              end
            end
            spi_front_pkg::kind_none: begin
              status_nxt = status_r;
            end
          endcase
        end
      end
      spi_front_pkg::st_busy: begin
        // Neither select nor the protect pin is looked at here
        if (tmr_r == `TMR_W'(0)) begin
          state_nxt           = spi_front_pkg::st_idle;
          status_nxt[`ST_WEL] = 1'b0;
        end else begin
          tmr_nxt = tmr_r - `TMR_W'(1);
        end
      end
    endcase
    status_nxt[`ST_WIP] = (state_nxt == spi_front_pkg::st_busy);
    // Standby only once deselected and idle
    standby_nxt = cs_sync_r & (state_nxt == spi_front_pkg::st_idle);
  end

  // Core registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r    <= spi_front_pkg::st_idle;
      tmr_r      <= {`TMR_W{1'b0}};
      status_r   <= `ST_RESET;
      armed_r    <= 1'b0;
      tag_seen_r <= 1'b0;
      wp_low_r   <= 1'b0;
      standby    <= 1'b1;
      write_busy <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      tmr_r      <= tmr_nxt;
      status_r   <= status_nxt;
      armed_r    <= armed_nxt;
      tag_seen_r <= tag_seen_nxt;
      wp_low_r   <= wp_low_nxt;
      standby    <= standby_nxt;
      write_busy <= status_nxt[`ST_WIP];
    end
  end

endmodule : spi_eeprom_select_protect_front

/* test/spi_front_chk.sv */
// Checker of the serial memory front end, core clock domain.
// Assumes binding to the top design module, reset active high.
`timescale 1ns/10ps
module spi_front_chk #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  // Device state
  input wire logic standby,
  input wire logic write_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] cnt_r;   // Busy cycles so far
  logic [31:0] cnt_nxt; // Next busy count
  // Count busy cycles; a counter avoids a long repetition
  always_comb begin
    cnt_nxt = write_busy ? cnt_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // Steps of a write cycle
  sequence busy_start;
    $rose(write_busy);
  endsequence
  sequence busy_run;
    write_busy [*8];
  endsequence
  oe_desel_a:
    assert property (cs_n |-> !so_oe) else $error("so driven while deselected");
  sel_wake_a:
    assert property (!cs_n [*4] |-> ##1 !standby) else $error("standby while selected");
  desel_idle_a:
    assert property ((cs_n && !write_busy) [*5] |-> ##1 standby) else $error("no standby when idle");
  busy_awake_a:
    assert property (write_busy && $past(write_busy) |-> !standby) else $error("standby during write");
  stby_after_a:
    assert property ($fell(write_busy) && cs_n |-> ##[0:2] standby) else $error("standby late after write");
  busy_hold_a:
    assert property (busy_start |-> busy_run) else $error("write cycle cut short");
  busy_max_a:
    assert property (cnt_r <= WRITE_CYCLES) else $error("write cycle too long");
  busy_min_a:
    assert property ($fell(write_busy) |-> cnt_r >= WRITE_CYCLES - 1) else $error("write cycle ended early");
  busy_cause_a:
    assert property (busy_start |-> cs_n && $past(cs_n)) else $error("write began while selected");
endmodule : spi_front_chk

bind spi_eeprom_select_protect_front spi_front_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
  .so(so), .so_oe(so_oe), .standby(standby), .write_busy(write_busy));

/* test/spi_host_model.sv */
// Host controller of the serial link, mode 0, 15 ns clock.
// Assumes the bench calls xfer only between frames.
`timescale 1ns/10ps
module spi_host_model (
  // Pins toward the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  // Answer from the device
  input  wire logic so,
  input  wire logic so_oe
);
  logic oe_seen; // Device drove so during last frame
  // Idle bus: clock parked low, deselected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_seen = 1'b0;
  end
  // One frame of nbits; clock runs only inside it
  task automatic xfer(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    #20;
    for (int i = nbits - 1; i >= 0; i--) begin
      si = tx[i];
      #7.5 sck = 1'b1;
      // An undriven line reads as the inverse, so a stale bit never passes
      rx = {rx[46:0], so_oe ? so : ~so};
      oe_seen |= so_oe;
      #7.5 sck = 1'b0;
    end
    #20 cs_n = 1'b1;
    si = ~si; // Released line shows no stale bit
    #250;
  endtask : xfer
endmodule : spi_host_model

/* test/tb_top.sv */
// Self-checking bench of the serial memory front end.
// Assumes design files, checker and host model compile first.
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  localparam int unsigned WC = 20; // Short write cycle
  logic        clk;        // Core clock
  logic        reset;      // Async reset
  logic        wp_n;       // Protect pin
  logic        sck;        // Link clock
  logic        cs_n;       // Select
  logic        si;         // Host data
  logic        so;         // Device data
  logic        so_oe;      // Device drive
  logic        standby;    // Standby flag
  logic        write_busy; // Write cycle flag
  int          n_mismatch; // Mismatches
  int          num_checks; // Comparisons
  int          n;          // Wait count
  logic [47:0] rx;         // Last frame received
  logic [7:0]  img [256];  // Expected array
  logic [7:0]  a;          // Test address
  always #25 clk = ~clk;
  spi_eeprom_select_protect_front #(.WRITE_CYCLES(WC)) u_dut (
    .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .standby(standby), .write_busy(write_busy));
  spi_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  // Expected two-byte read; address wraps at 256
  function automatic logic [15:0] exp_rd(input logic [7:0] ad);
    return {img[ad], img[ad + 8'h1]};
  endfunction : exp_rd
  // Expected status byte
  function automatic logic [7:0] exp_st(input logic pe, input logic [1:0] bp, input logic wel);
    return {pe, 3'b000, bp, wel, 1'b0};
  endfunction : exp_st
  // Frame launched off the falling core edge
  task automatic cmd(input logic [47:0] tx, input int nb);
    @(negedge clk);
    u_host.xfer(tx, nb, rx);
  endtask : cmd
  // Bounded wait for the busy flag
  task automatic wait_busy(input logic v);
    n = 0;
    while (write_busy !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
    `CHK(write_busy, v)
  endtask : wait_busy
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    cmd(48'h06, 8);
    cmd({8'h02, 8'h00, ad, dt}, 32);
    img[ad] = dt;
    wait_busy(1'b1);
    wait_busy(1'b0);
    `CHK(n <= WC + 1, 1'b1)
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    cmd({8'h03, 8'h00, ad, 16'h0}, 40);
    `CHK(rx[15:0], exp_rd(ad))
  endtask : rd
  // Status write; accepted ones run a cycle, pin dropped mid-cycle
  task automatic wrsr(input logic [7:0] v, input logic ok);
    cmd(48'h06, 8);
    cmd({8'h01, v}, 16);
    if (ok) begin
      wait_busy(1'b1);
      @(negedge clk);
      wp_n = 1'b0;
      wait_busy(1'b0);
    end
  endtask : wrsr
  task automatic rdsr(input logic [7:0] e);
    cmd(48'h0500, 16);
    `CHK(rx[7:0], e)
  endtask : rdsr
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // Watchdog well past the expected run
  initial begin
    #3000000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    wp_n = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    n = $urandom(32'h50847732);
    repeat (8) @(negedge clk);
    reset = 1'b0;
    `CHK({standby, write_busy, so_oe}, 3'b100)
    cmd(48'h0, 1);
    `CHK(write_busy, 1'b0)
    endt("reset");
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 8'hff : 8'($urandom);
      wr(a, 8'($urandom));
      wr(a + 8'h1, 8'($urandom));
      rd(a);
    end
    endt("array");
    cmd(48'h06, 8);
    cmd({8'h02, 8'h00, a, ~img[a]}, 32);
    img[a] = ~img[a];
    wait_busy(1'b1);
    cmd({8'h03, 8'h00, a, 8'h00}, 32);
    `CHK(u_host.oe_seen, 1'b0)
    wait_busy(1'b0);
    rd(a);
    cmd({8'h02, 8'h00, a, 8'h5a}, 32);
    `CHK(write_busy, 1'b0)
    // Latch set, then cleared again: the write must be dropped
    cmd(48'h06, 8);
    cmd(48'h04, 8);
    cmd({8'h02, 8'h00, a, 8'h5a}, 32);
    `CHK(write_busy, 1'b0)
    // Write cut one bit short of its last data byte
    cmd(48'h06, 8);
    cmd({8'h02, 8'h00, a, 7'h2d}, 31);
    `CHK(write_busy, 1'b0)
    rd(a);
    endt("busy");
    @(negedge clk);
    wp_n = 1'b0;
    wrsr(8'h8c, 1'b1);
    rdsr(exp_st(1'b1, 2'b11, 1'b0));
    wrsr(8'h00, 1'b0);
    rdsr(exp_st(1'b1, 2'b11, 1'b1));
    @(negedge clk);
    wp_n = 1'b1;
    wrsr(8'h00, 1'b1);
    rdsr(exp_st(1'b0, 2'b00, 1'b0));
    endt("protect");
    finish_test();
  end
endmodule : tb_top
